/* verilog/hall_readout_pkg.sv */
// constants and carrier types for the hall sensor sampling and readout block
`default_nettype none

package hall_readout_pkg;

  // ---------------------------------------------------------------
  // clock and acquisition timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_MHZ       = 20;
  localparam int SECOND_TRACK_US    = 32;
  localparam int SECOND_HOLD_US     = 96;
  localparam int ACQ_COUNT_BITS     = 11;
  localparam logic [ACQ_COUNT_BITS-1:0] SECOND_TRACK_CYCLES =
    ACQ_COUNT_BITS'(SECOND_TRACK_US * CLK_FREQ_MHZ);
  localparam logic [ACQ_COUNT_BITS-1:0] SECOND_HOLD_CYCLES =
    ACQ_COUNT_BITS'(SECOND_HOLD_US * CLK_FREQ_MHZ);

  // ---------------------------------------------------------------
  // data and command layout
  // ---------------------------------------------------------------
  localparam int DATA_BITS       = 12;
  localparam int FRAC_BITS       = 7;
  localparam int ACC_BITS        = DATA_BITS + FRAC_BITS;
  localparam int CMD_BITS        = 16;
  localparam int BIT_COUNT_BITS  = 5;
  localparam int CMD_OP_MSB      = 15;
  localparam int CMD_OP_LSB      = 14;
  localparam int CMD_FILTER_MSB  = 13;
  localparam int CMD_FILTER_LSB  = 11;
  localparam int CMD_TRIM_MSB    = 10;
  localparam int CMD_TRIM_LSB    = 5;
  localparam int CMD_BURN_POS    = 0;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [BIT_COUNT_BITS-1:0] CMD_LENGTH =
    BIT_COUNT_BITS'(CMD_BITS);

  // filter weight code and full scale trim code
  typedef struct packed {
    logic [2:0] filter;
    logic [5:0] trim;
  } sensor_config_t;

  localparam sensor_config_t CONFIG_RESET = '{filter: 3'h0, trim: 6'h00};

  // controls to the analog sample pair and converter
  typedef struct packed {
    logic track_first;
    logic track_second;
    logic convert_start;
  } afe_control_t;

  // answer of the converter: signed difference of the sample pair
  typedef struct packed {
    logic                       valid;
    logic signed [DATA_BITS-1:0] diff;
  } conversion_t;

endpackage

`default_nettype wire

/* verilog/hall_sample_serial_readout.sv */
// sampling sequencer, filter and serial readout of the hall sensor
`default_nettype none

// Overview of operation
// - sensed flux, plus or minus 500 gauss, becomes a 12-bit serial word
// - device is only a link slave; serial output is a three-state driver
// - filter and trim set over the link, reloaded from one-time memory
// - first sample tracks the hall signal while select is high, except between a select fall and the second hold
// - first sample is held right after select falls
// - second sample starts tracking 32 us after select falls
// - second sample held at 96 us, then the pair difference converts
// - finished result loads the output shifter at the next select fall
// - acquisition timing runs apart from the serial shift clock
// - zero field reads 2048; north pole on top raises the count
// - input sampled on rising shift clock, output changes after falling
// - output high impedance and link ignored while select is high
// - 3-bit filter code halves moving-average weight per step, to 1/128
// - burn pulse fires at select fall of the command after a burn one

module hall_sample_serial_readout (
  input  wire logic                           CLOCK,
  input  wire logic                           RESET_N,
  input  wire logic                           SELECT_N,
  input  wire logic                           SHIFT_CLOCK,
  input  wire logic                           SERIAL_IN_LINE,
  output logic                                SERIAL_OUT_LINE_O,
  output logic                                SERIAL_OUT_LINE_OE_N,
  output hall_readout_pkg::afe_control_t      AFE_CONTROL,
  input  wire hall_readout_pkg::conversion_t  CONVERSION,
  output hall_readout_pkg::sensor_config_t    ACTIVE_CONFIG,
  input  wire hall_readout_pkg::sensor_config_t STORED_CONFIG,
  output logic                                BURN_PULSE,
  output hall_readout_pkg::sensor_config_t    BURN_VALUE
);
  import hall_readout_pkg::*;

  typedef enum logic [1:0] {
    S_TRACK_FIRST, S_HOLD_FIRST, S_TRACK_SECOND, S_CONVERT
  } acq_state_t;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [2:0] sel_meta, sel_sync;
  logic [1:0] sel_prev;
  logic       sel_high, sel_fall, sel_rise, sck_rise, sck_fall, serial_in_line;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel_meta <= 3'h1;
      sel_sync <= 3'h1;
      sel_prev <= 2'h1;
    end else begin
      sel_meta <= {SERIAL_IN_LINE, SHIFT_CLOCK, SELECT_N};
      sel_sync <= sel_meta;
      sel_prev <= sel_sync[1:0];
    end
  end

  assign sel_high = sel_sync[0];
  assign sel_fall = sel_prev[0] & ~sel_sync[0];
  assign sel_rise = ~sel_prev[0] & sel_sync[0];
  assign sck_rise = ~sel_high & ~sel_prev[1] & sel_sync[1];
  assign sck_fall = ~sel_high & sel_prev[1] & ~sel_sync[1];
  assign serial_in_line      = sel_sync[2];

  // ---------------------------------------------------------------
  // acquisition sequencer
  // ---------------------------------------------------------------
  acq_state_t                state, next_state;
  logic [ACQ_COUNT_BITS-1:0] acq_count;
  logic                      at_second_track, at_second_hold;

  assign at_second_track = acq_count == SECOND_TRACK_CYCLES;
  assign at_second_hold  = acq_count == SECOND_HOLD_CYCLES;

  always_comb begin
    next_state = state;
    case (state)
      S_TRACK_FIRST:  next_state = state;
      S_HOLD_FIRST:   if (at_second_track) next_state = S_TRACK_SECOND;
      S_TRACK_SECOND: if (at_second_hold) next_state = S_CONVERT;
      S_CONVERT:      if (CONVERSION.valid) next_state = S_TRACK_FIRST;
      default:        next_state = S_TRACK_FIRST;
    endcase
    if (sel_fall)
      next_state = S_HOLD_FIRST;
  end

  // system-clock timebase, cleared at select fall and stopping at all ones, no link clock involved
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state     <= S_TRACK_FIRST;
      acq_count <= '0;
    end else begin
      state <= next_state;
      if (sel_fall)
        acq_count <= '0;
      else if (acq_count != '1)
        acq_count <= acq_count + 1'b1;
    end
  end

  always_comb begin
    AFE_CONTROL.track_first   = sel_high & (state == S_TRACK_FIRST
                                            | state == S_CONVERT);
    AFE_CONTROL.track_second  = state == S_TRACK_SECOND;
    AFE_CONTROL.convert_start = state == S_TRACK_SECOND
                                & at_second_hold;
  end

  // ---------------------------------------------------------------
  // offset code and moving-average filter
  // ---------------------------------------------------------------
  sensor_config_t            cfg;
  logic                      cfg_loaded;
  logic [ACC_BITS-1:0]       acc, next_acc;
  logic [DATA_BITS-1:0]      code, result;
  logic signed [ACC_BITS:0]  filt_diff, filt_step;
  logic                      take_sample;

  // mid-scale offset: signed difference plus 2048
  assign code        = {~CONVERSION.diff[DATA_BITS-1],
                        CONVERSION.diff[DATA_BITS-2:0]};
  assign filt_diff   = $signed({1'b0, code, {FRAC_BITS{1'b0}}})
                       - $signed({1'b0, acc});
  assign filt_step   = filt_diff >>> cfg.filter;
  assign next_acc    = acc + filt_step[ACC_BITS-1:0];
  assign result      = acc[ACC_BITS-1:FRAC_BITS];
  assign take_sample = state == S_CONVERT & CONVERSION.valid;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N)
      acc <= '0;
    else if (take_sample)
      acc <= next_acc;
  end

  // ---------------------------------------------------------------
  // serial output shifter
  // ---------------------------------------------------------------
  logic [DATA_BITS-1:0] out_shift;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N)
      out_shift <= '0;
    else if (sel_fall)
      out_shift <= result;
    else if (sck_fall)
      out_shift <= {out_shift[DATA_BITS-2:0], 1'b0};
  end

  assign SERIAL_OUT_LINE_O    = out_shift[DATA_BITS-1];
  assign SERIAL_OUT_LINE_OE_N = sel_high;

  // ---------------------------------------------------------------
  // command capture, preview and one-time programming
  // ---------------------------------------------------------------
  logic [CMD_BITS-1:0]       in_shift;
  logic [BIT_COUNT_BITS-1:0] bit_count;
  logic                      cmd_write, burn_armed;
  sensor_config_t            cmd_value;

  assign cmd_write = sel_rise & bit_count == CMD_LENGTH
                     & in_shift[CMD_OP_MSB:CMD_OP_LSB] == CMD_WRITE;
  assign cmd_value = '{filter: in_shift[CMD_FILTER_MSB:CMD_FILTER_LSB],
                       trim:   in_shift[CMD_TRIM_MSB:CMD_TRIM_LSB]};

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      in_shift  <= '0;
      bit_count <= '0;
    end else if (sel_fall) begin
      bit_count <= '0;
    end else if (sck_rise) begin
      in_shift  <= {in_shift[CMD_BITS-2:0], serial_in_line};
      if (bit_count != '1)
        bit_count <= bit_count + 1'b1;
    end
  end

  // stored settings taken once, on the first edge after reset release
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg        <= CONFIG_RESET;
      cfg_loaded <= 1'b0;
    end else if (!cfg_loaded) begin
      cfg        <= STORED_CONFIG;
      cfg_loaded <= 1'b1;
    end else if (cmd_write) begin
      cfg        <= cmd_value;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      burn_armed <= 1'b0;
      BURN_VALUE <= CONFIG_RESET;
      BURN_PULSE <= 1'b0;
    end else begin
      BURN_PULSE <= sel_fall & burn_armed;
      if (sel_fall)
        burn_armed <= 1'b0;
      else if (cmd_write & in_shift[CMD_BURN_POS]) begin
        burn_armed <= 1'b1;
        BURN_VALUE <= cmd_value;
      end
    end
  end

  assign ACTIVE_CONFIG = cfg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  a_output_idle_hiz: assert property (
    sel_high |-> SERIAL_OUT_LINE_OE_N ##1 $stable(in_shift)
      && $stable(out_shift) && $stable(bit_count))
    else $error("link active while select high");
  a_output_driven: assert property (
    !sel_high |-> !SERIAL_OUT_LINE_OE_N)
    else $error("output not driven while selected");
  a_first_hold: assert property (
    sel_fall |=> state == S_HOLD_FIRST && !AFE_CONTROL.track_first)
    else $error("first sample not held after select fall");
  a_second_track: assert property (
    $rose(AFE_CONTROL.track_second) |->
      acq_count == SECOND_TRACK_CYCLES + 1'b1)
    else $error("second track start at wrong time");
  a_second_hold: assert property (
    AFE_CONTROL.convert_start |=> !AFE_CONTROL.track_second
      && $past(acq_count) == SECOND_HOLD_CYCLES)
    else $error("second hold at wrong time");
  a_result_load: assert property (
    sel_fall |=> out_shift == $past(result))
    else $error("result not loaded at select fall");
  a_shift_out: assert property (
    sck_fall && !sel_fall |=> out_shift == {$past(out_shift[10:0]), 1'b0})
    else $error("output shifter did not advance");
  a_unfiltered_code: assert property (
    take_sample && cfg.filter == 3'h0 |=>
      result == {~$past(CONVERSION.diff[11]), $past(CONVERSION.diff[10:0])})
    else $error("unfiltered code wrong");
  a_stored_reload: assert property (
    $rose(cfg_loaded) |-> cfg == $past(STORED_CONFIG))
    else $error("stored settings not reloaded");
  a_burn_timing: assert property (
    BURN_PULSE |-> $past(sel_fall) && $past(burn_armed) ##1 !BURN_PULSE)
    else $error("burn pulse at wrong time");
  a_input_capture: assert property (
    sck_rise && !sel_fall |=> in_shift[0] == $past(serial_in_line))
    else $error("serial input not captured");

  c_conversion: cover property (take_sample);
  c_write_preview: cover property (cmd_write && !in_shift[CMD_BURN_POS]);
  c_burn: cover property (BURN_PULSE);
  c_read_word: cover property (sel_rise && bit_count >= 5'h0C);

endmodule // hall_sample_serial_readout

`default_nettype wire

/* test/hall_master_model.sv */
// serial master model driving select, shift clock and serial input
`default_nettype none

module hall_master_model (
  output logic        sel_n,
  output logic        sck,
  output logic        serial_in_line,
  input  wire logic   serial_out_line,
  output logic [11:0] rd,
  output logic        done
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    serial_in_line = 1'b0;
    rd = '0;
    done = 1'b0;
  end

  // one 16-bit frame; junk clocks follow while select is high again
  task automatic frame(input logic [15:0] cmd, input int junk);
    #13 sel_n = 1'b0;
    #400;
    for (int i = 15; i >= 0; i--) begin
      serial_in_line = cmd[i];
      #200 sck = 1'b1;
      #190 if (i > 3) rd[i-4] = serial_out_line;
      #10 sck = 1'b0;
    end
    #200 sel_n = 1'b1;
    // released input shows the inverse of its last value
    serial_in_line = ~serial_in_line;
    done = ~done;
    repeat (junk) begin
      #200 sck = 1'b1;
      serial_in_line = ~serial_in_line;
      #200 sck = 1'b0;
    end
  endtask

endmodule // hall_master_model

`default_nettype wire

/* test/hall_sample_serial_readout_tb_top.sv */
// self-checking bench of the hall sampling and serial readout block
`default_nettype none

module hall_sample_serial_readout_tb_top;
  import hall_readout_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic             clock;
  logic             reset_n;
  wire logic        sel_n;
  wire logic        sck;
  wire logic        serial_in_line;
  wire logic        done;
  wire logic [11:0] rd;
  tri1              sdo_wire;
  logic             sdo_o;
  logic             sdo_oe_n;
  logic             burn_pulse;
  afe_control_t     afe;
  conversion_t      conv;
  sensor_config_t   active_cfg;
  sensor_config_t   stored_cfg;
  sensor_config_t   burn_val;
  sensor_config_t   cfg;
  sensor_config_t   burn_exp;
  logic [18:0]      acc;
  logic [11:0]      exp_q[$];
  int               err_total;
  int               n_compared;
  int               n_burn;
  time              t_fall;

  assign sdo_wire = sdo_oe_n ? 1'bz : sdo_o;

  hall_sample_serial_readout i_hall_sample_serial_readout (
    .CLOCK                (clock),
    .RESET_N              (reset_n),
    .SELECT_N             (sel_n),
    .SHIFT_CLOCK          (sck),
    .SERIAL_IN_LINE       (serial_in_line),
    .SERIAL_OUT_LINE_O    (sdo_o),
    .SERIAL_OUT_LINE_OE_N (sdo_oe_n),
    .AFE_CONTROL          (afe),
    .CONVERSION           (conv),
    .ACTIVE_CONFIG        (active_cfg),
    .STORED_CONFIG        (stored_cfg),
    .BURN_PULSE           (burn_pulse),
    .BURN_VALUE           (burn_val)
  );

  hall_master_model i_hall_master_model (
    .sel_n (sel_n),
    .sck   (sck),
    .serial_in_line   (serial_in_line),
    .serial_out_line   (sdo_wire),
    .rd    (rd),
    .done  (done)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic stop_test;
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // converter answers each start after a random latency
  initial begin : converter
    int d;
    conv = '0;
    forever begin
      @(negedge clock);
      if (afe.convert_start === 1'b1) begin
        repeat ($urandom_range(1, 40)) @(negedge clock);
        conv.diff = 12'($urandom);
        conv.valid = 1'b1;
        d = (int'({~conv.diff[11], conv.diff[10:0]}) << 7) - int'(acc);
        acc = 19'(int'(acc) + (d >>> cfg.filter));
        exp_q.push_back(acc[18:7]);
        @(negedge clock) conv.valid = 1'b0;
      end
    end
  end

  always @(done)
    if (reset_n) check("read word", rd, exp_q.pop_front());

  always @(negedge clock)
    if (burn_pulse === 1'b1) begin
      n_burn++;
      check("burn value", burn_val, burn_exp);
    end

  always @(negedge sel_n) t_fall = $time;

  always @(negedge clock)
    if (afe.convert_start === 1'b1)
      check("convert delay", ($time - t_fall) / 50 inside {[1921:1926]},
            1'b1);

  always @(posedge afe.track_second)
    if (reset_n === 1'b1)
      check("track delay", ($time - t_fall) / 50 inside {[641:646]},
            1'b1);

  initial begin
    logic [15:0] cmd;
    void'($urandom(32'h71b8248f));
    reset_n = 1'b0;
    stored_cfg = sensor_config_t'(9'($urandom));
    cfg = stored_cfg;
    burn_exp = '0;
    acc = '0;
    exp_q.push_back(12'h000);
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    check("config after reset", active_cfg, cfg);
    // writes with every filter code, burn at code 3, then a noisy read
    for (int k = 0; k < 9; k++) begin
      check("tracking first", afe.track_first, 1'b1);
      cmd = {CMD_WRITE, 3'(k), 6'($urandom), 4'h0, k == 3};
      if (k == 8) cmd = 16'h0000;
      i_hall_master_model.frame(cmd, (k == 8) ? 12 : 0);
      if (cmd[15:14] == CMD_WRITE)
        cfg = '{filter: cmd[13:11], trim: cmd[10:5]};
      if (k == 3) burn_exp = cfg;
      repeat (5) @(negedge clock);
      check("output enable", sdo_oe_n, 1'b1);
      check("active config", active_cfg, cfg);
      repeat (9900) @(negedge clock);
    end
    // second power-on: stored settings reload, filter history cleared
    stored_cfg = sensor_config_t'(9'($urandom));
    cfg = stored_cfg;
    reset_n = 1'b0;
    repeat (5) @(negedge clock);
    acc = '0;
    exp_q.delete();
    exp_q.push_back(12'h000);
    reset_n = 1'b1;
    @(negedge clock);
    check("config reload", active_cfg, cfg);
    i_hall_master_model.frame(16'h0000, 0);
    repeat (5) @(negedge clock);
    check("burn pulses", n_burn, 1);
    stop_test;
  end

  initial begin
    #5_000_000;
    err_total++;
    stop_test;
  end

endmodule // hall_sample_serial_readout_tb_top

`default_nettype wire
